// File: inc/acdp_defines.svh
// Purpose: offsets, field positions, reset values of the aux control block
// Assumes: 32-bit AXI4-Lite data, each register one aligned word
// Notes:   Functional notes follow
//
// Functional notes
// - writing a one at bit 3 of aux control resets all block registers
// - two data pointers; the select bit picks the one every access uses
// - the unselected pointer is hidden and keeps its value unchanged
// - increment, load, jump and code/data moves use only the selected pointer
// - high and low byte accesses reach the selected pointer only
// - bit 2 of aux control always reads zero and ignores writes
// - external data moves are routed to on-chip configuration space
// - brownout disable bit set switches brownout detection off
// - brownout interrupt mode set: no chip reset, an interrupt instead
`ifndef ACDP_DEFINES_SVH
`define ACDP_DEFINES_SVH

`define ACDP_OFS_AUX   8'h00
`define ACDP_OFS_PLO   8'h04
`define ACDP_OFS_PHI   8'h08
`define ACDP_OFS_STAT  8'h0c
`define ACDP_OFS_MASK  8'h10
`define ACDP_OFS_KBEN  8'h14

`define ACDP_BIT_DPS   0
`define ACDP_BIT_SOFT_RESET_BIT  3
`define ACDP_BIT_BOI   5
`define ACDP_BIT_BOD   6
`define ACDP_BIT_KBF   7

`define ACDP_STAT_BO   0
`define ACDP_STAT_KB   1

`define ACDP_AUX_RST   8'h00
`define ACDP_PTR_RST   16'h0000
`define ACDP_STAT_RST  2'h0
`define ACDP_KBEN_RST  8'h00

`define ACDP_RESP_OKAY 2'h0
`define ACDP_RESP_SLV  2'h2

`endif

// File: inc/acdp_pkg.sv
// Purpose: shared types of the aux control block
// Assumes: used by qualified names only
// Notes:   register select is a decode result, not a state
package acdp_pkg;
  typedef logic [15:0] acdp_ptr_t;
  typedef logic [7:0]  acdp_byte_t;
  typedef enum logic [2:0] {
    ACDP_R_AUX, ACDP_R_PLO, ACDP_R_PHI, ACDP_R_STAT,
    ACDP_R_MASK, ACDP_R_KBEN, ACDP_R_NONE
  } acdp_reg_t;
endpackage

// File: rtl/acdp_data_pointer.sv
// Purpose: bank of two data pointers, one visible at a time
// Assumes: select and commands come from logic on aclk
// Notes:   byte write beats load beats increment in one cycle
`timescale 1ns/1ps
`include "acdp_defines.svh"
module acdp_data_pointer (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              soft_rst,
  // selection and commands
  input  wire logic              sel,
  input  wire logic              inc,
  input  wire logic              load,
  input  wire acdp_pkg::acdp_ptr_t load_val,
  input  wire logic              wr_lo,
  input  wire logic              wr_hi,
  input  wire acdp_pkg::acdp_byte_t byte_val,
  // selected pointer
  output acdp_pkg::acdp_ptr_t    cur
);
  acdp_pkg::acdp_ptr_t ptr_r [2];

  // only the pointer picked by sel ever changes
  for (genvar i = 0; i < 2; i++) begin : g_ptr
    always_ff @(posedge aclk) begin
      if (!aresetn || soft_rst) begin
        ptr_r[i] <= `ACDP_PTR_RST;
      end else if (sel == 1'(i)) begin
        if (wr_lo) begin
          ptr_r[i][7:0] <= byte_val;
        end else if (wr_hi) begin
          ptr_r[i][15:8] <= byte_val;
        end else if (load) begin
          ptr_r[i] <= load_val;
        end else if (inc) begin
          ptr_r[i] <= ptr_r[i] + 16'h0001;
        end
      end
    end
  end

  assign cur = ptr_r[sel];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || soft_rst);

  chk_hidden_hold: assert property (sel |=> $stable(ptr_r[0]))
    else $error("unselected pointer changed");
  chk_inc_selected: assert property (
    (inc && !load && !wr_lo && !wr_hi) ##1 $stable(sel) |-> cur == $past(cur) + 16'h0001)
    else $error("increment did not add one to selected pointer");
  chk_low_byte: assert property (wr_lo ##1 $stable(sel) |-> cur[7:0] == $past(byte_val))
    else $error("low byte write missed selected pointer");
endmodule

// File: rtl/acdp_irq.sv
// Purpose: sticky event status, mask and one level interrupt
// Assumes: events are one-cycle pulses on aclk
// Notes:   a set in the clearing cycle wins, so no event is lost
`timescale 1ns/1ps
module acdp_irq #(
  parameter int N = 2
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         soft_rst,
  // events and software access
  input  wire logic [N-1:0] set,
  input  wire logic         clr_wr,
  input  wire logic [N-1:0] clr_val,
  input  wire logic         mask_wr,
  input  wire logic [N-1:0] mask_val,
  // state and interrupt
  output logic [N-1:0]      status_r,
  output logic [N-1:0]      mask_r,
  output logic              irq
);
  initial if (N < 1 || N > 8) $error("acdp_irq: N out of range");

  // write one to clear, hardware set has priority
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~(clr_wr ? clr_val : '0)) | set;
    end
  end

  // mask of the same layout as status
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      mask_r <= '0;
    end else if (mask_wr) begin
      mask_r <= mask_val;
    end
  end

  assign irq = |(status_r & mask_r);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || soft_rst);

  chk_set_wins: assert property (set[0] |=> status_r[0])
    else $error("event lost against clear");
endmodule

// File: rtl/acdp_top.sv
// Purpose: aux feature control register, dual data pointer, brownout and
//          keyboard wake control behind an AXI4-Lite slave
// Assumes: one clock aclk at 50 MHz; pins are asynchronous and synchronised
// Notes:   one write and one read in flight; a write answers one edge after taking, a read on the taking edge
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "acdp_defines.svh"
module acdp_top #(
  parameter int ADDR_W = 8,
  parameter int KB_W   = 8
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address and data
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // axi4-lite write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // core pointer commands
  input  wire logic              ptr_inc,
  input  wire logic              ptr_load,
  input  wire acdp_pkg::acdp_ptr_t ptr_load_val,
  input  wire logic              xdata_req,
  output acdp_pkg::acdp_ptr_t    ptr_value,
  // configuration space access
  output logic                   cfg_access,
  output acdp_pkg::acdp_ptr_t    cfg_addr,
  // brownout and keyboard pins
  input  wire logic              brownout_det,
  input  wire logic [KB_W-1:0]   kb_pin_n,
  output logic                   brownout_det_en,
  output logic                   brownout_reset_req,
  // system reset request and interrupt
  output logic                   soft_reset_req,
  output logic                   irq
);
  initial begin
    if (ADDR_W < 5 || ADDR_W > 32) $error("acdp_top: ADDR_W out of range");
    if (KB_W < 1 || KB_W > 8) $error("acdp_top: KB_W out of range");
  end

  // register select from a byte address; unaligned or unknown is none
  function automatic acdp_pkg::acdp_reg_t dec(input logic [ADDR_W-1:0] a);
    acdp_pkg::acdp_reg_t r;
    r = acdp_pkg::ACDP_R_NONE;
    if (a == ADDR_W'(`ACDP_OFS_AUX))  r = acdp_pkg::ACDP_R_AUX;
    if (a == ADDR_W'(`ACDP_OFS_PLO))  r = acdp_pkg::ACDP_R_PLO;
    if (a == ADDR_W'(`ACDP_OFS_PHI))  r = acdp_pkg::ACDP_R_PHI;
    if (a == ADDR_W'(`ACDP_OFS_STAT)) r = acdp_pkg::ACDP_R_STAT;
    if (a == ADDR_W'(`ACDP_OFS_MASK)) r = acdp_pkg::ACDP_R_MASK;
    if (a == ADDR_W'(`ACDP_OFS_KBEN)) r = acdp_pkg::ACDP_R_KBEN;
    return r;
  endfunction

  // write channel capture
  logic                aw_got_r;
  logic                w_got_r;
  logic [ADDR_W-1:0]   awaddr_r;
  logic [7:0]          wbyte_r;
  logic                wlane_r;
  logic                bvalid_r;
  logic [1:0]          bresp_r;
  logic                wr_fire;
  acdp_pkg::acdp_reg_t wr_reg;
  logic                wr_en;

  // read channel
  logic                rvalid_r;
  logic [31:0]         rdata_r;
  logic [1:0]          rresp_r;
  acdp_pkg::acdp_reg_t rd_reg;

  // aux control fields
  logic                kbf_r;
  logic                bod_r;
  logic                boi_r;
  logic                dps_r;
  logic                soft_rst_r;
  logic [7:0]          kb_en_r;
  logic [7:0]          aux_rd;

  // synchronisers and event detect
  logic                bo_s1_r;
  logic                bo_s2_r;
  logic                bo_prev_r;
  logic [KB_W-1:0]     kb_s1_r;
  logic [KB_W-1:0]     kb_s2_r;
  logic [KB_W-1:0]     kb_act;
  logic [KB_W-1:0]     kb_prev_r;
  logic                kb_rise;
  logic                bo_rise;
  logic                bo_rst_r;

  // outputs toward configuration space
  logic                cfg_acc_r;
  acdp_pkg::acdp_ptr_t cfg_addr_r;

  // interrupt block
  logic [1:0]          stat;
  logic [1:0]          mask;
  logic [1:0]          ev;

  // write handshake: address and data taken in any order
  assign awready = !aw_got_r && !bvalid_r;
  assign wready  = !w_got_r && !bvalid_r;
  assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
  assign wr_reg  = dec(awaddr_r);
  assign wr_en   = wr_fire && wlane_r; // only lane 0 carries register data

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      awaddr_r <= '0;
    end else if (awvalid && awready) begin
      aw_got_r <= 1'b1;
      awaddr_r <= awaddr;
    end else if (wr_fire) begin
      aw_got_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_r <= 1'b0;
      wbyte_r <= 8'h00;
      wlane_r <= 1'b0;
    end else if (wvalid && wready) begin
      w_got_r <= 1'b1;
      wbyte_r <= wdata[7:0];
      wlane_r <= wstrb[0];
    end else if (wr_fire) begin
      w_got_r <= 1'b0;
    end
  end

  // write response held until bready; unmapped answers slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `ACDP_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= (wr_reg == acdp_pkg::ACDP_R_NONE) ? `ACDP_RESP_SLV : `ACDP_RESP_OKAY;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign bvalid = bvalid_r;
  assign bresp  = bresp_r;

  // read answer registered on the edge that takes the address, held until rready
  assign arready = !rvalid_r;
  assign rd_reg  = dec(araddr);
  // bits 4..1 read zero; bit 3 is self clearing
  assign aux_rd  = {kbf_r, bod_r, boi_r, 4'h0, dps_r};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `ACDP_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_r <= 1'b1;
      rresp_r  <= `ACDP_RESP_OKAY;
      unique case (rd_reg)
        acdp_pkg::ACDP_R_AUX:  rdata_r <= {24'h0, aux_rd};
        acdp_pkg::ACDP_R_PLO:  rdata_r <= {24'h0, ptr_value[7:0]};
        acdp_pkg::ACDP_R_PHI:  rdata_r <= {24'h0, ptr_value[15:8]};
        acdp_pkg::ACDP_R_STAT: rdata_r <= {30'h0, stat};
        acdp_pkg::ACDP_R_MASK: rdata_r <= {30'h0, mask};
        acdp_pkg::ACDP_R_KBEN: rdata_r <= {24'h0, kb_en_r};
        acdp_pkg::ACDP_R_NONE: begin
          rdata_r <= 32'h0000_0000;
          rresp_r <= `ACDP_RESP_SLV;
        end
      endcase
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign rvalid = rvalid_r;
  assign rdata  = rdata_r;
  assign rresp  = rresp_r;

  // soft reset: one pulse out, and all block registers reinitialise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= wr_en && wr_reg == acdp_pkg::ACDP_R_AUX && wbyte_r[`ACDP_BIT_SOFT_RESET_BIT];
    end
  end

  assign soft_reset_req = soft_rst_r;

  // aux control fields; bits 4, 2, 1 are not stored so writes vanish,
  // which lets software toggle select by adding one to the register
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst_r) begin
      bod_r <= 1'(`ACDP_AUX_RST >> `ACDP_BIT_BOD);
      boi_r <= 1'(`ACDP_AUX_RST >> `ACDP_BIT_BOI);
      dps_r <= 1'(`ACDP_AUX_RST >> `ACDP_BIT_DPS);
    end else if (wr_en && wr_reg == acdp_pkg::ACDP_R_AUX) begin
      bod_r <= wbyte_r[`ACDP_BIT_BOD];
      boi_r <= wbyte_r[`ACDP_BIT_BOI];
      dps_r <= wbyte_r[`ACDP_BIT_DPS];
    end
  end

  // keyboard wake flag: pin event wins over a software clear
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst_r) begin
      kbf_r <= 1'b0;
    end else if (kb_rise) begin
      kbf_r <= 1'b1;
    end else if (wr_en && wr_reg == acdp_pkg::ACDP_R_AUX && !wbyte_r[`ACDP_BIT_KBF]) begin
      kbf_r <= 1'b0;
    end
  end

  // keyboard pin enables
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst_r) begin
      kb_en_r <= `ACDP_KBEN_RST;
    end else if (wr_en && wr_reg == acdp_pkg::ACDP_R_KBEN) begin
      kb_en_r <= wbyte_r;
    end
  end

  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bo_s1_r <= 1'b0;
      bo_s2_r <= 1'b0;
      kb_s1_r <= '1;
      kb_s2_r <= '1;
    end else begin
      bo_s1_r <= brownout_det;
      bo_s2_r <= bo_s1_r;
      kb_s1_r <= kb_pin_n;
      kb_s2_r <= kb_s1_r;
    end
  end

  // event edges on the synchronised levels
  assign kb_act  = kb_en_r[KB_W-1:0] & ~kb_s2_r;
  assign kb_rise = |(kb_act & ~kb_prev_r);
  assign bo_rise = bo_s2_r && !bo_prev_r && !bod_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bo_prev_r <= 1'b0;
      kb_prev_r <= '0;
    end else begin
      bo_prev_r <= bo_s2_r;
      kb_prev_r <= kb_act;
    end
  end

  // brownout resets the chip only when detection is on and not in irq mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bo_rst_r <= 1'b0;
    end else begin
      bo_rst_r <= bo_s2_r && !bod_r && !boi_r;
    end
  end

  assign brownout_reset_req = bo_rst_r;
  assign brownout_det_en    = !bod_r;

  // pointer bank; byte writes come from the bus, the rest from the core
  acdp_data_pointer u_data_pointer (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .soft_rst (soft_rst_r),
    .sel      (dps_r),
    .inc      (ptr_inc),
    .load     (ptr_load),
    .load_val (ptr_load_val),
    .wr_lo    (wr_en && wr_reg == acdp_pkg::ACDP_R_PLO),
    .wr_hi    (wr_en && wr_reg == acdp_pkg::ACDP_R_PHI),
    .byte_val (wbyte_r),
    .cur      (ptr_value)
  );

  // no external data bus: data moves go to configuration space
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_acc_r  <= 1'b0;
      cfg_addr_r <= `ACDP_PTR_RST;
    end else begin
      cfg_acc_r  <= xdata_req;
      cfg_addr_r <= ptr_value;
    end
  end

  assign cfg_access = cfg_acc_r;
  assign cfg_addr   = cfg_addr_r;

  // interrupt sources: brownout in irq mode, keyboard wake
  assign ev[`ACDP_STAT_BO] = bo_rise && boi_r;
  assign ev[`ACDP_STAT_KB] = kb_rise;

  acdp_irq #(.N(2)) u_irq (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .soft_rst (soft_rst_r),
    .set      (ev),
    .clr_wr   (wr_en && wr_reg == acdp_pkg::ACDP_R_STAT),
    .clr_val  (wbyte_r[1:0]),
    .mask_wr  (wr_en && wr_reg == acdp_pkg::ACDP_R_MASK),
    .mask_val (wbyte_r[1:0]),
    .status_r (stat),
    .mask_r   (mask),
    .irq      (irq)
  );

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_soft_reset_bit_write;
    wr_en && wr_reg == acdp_pkg::ACDP_R_AUX && wbyte_r[`ACDP_BIT_SOFT_RESET_BIT];
  endsequence

  sequence s_reset_done;
    soft_reset_req ##1 (!dps_r && !bod_r && !boi_r && stat == 2'h0);
  endsequence

  chk_soft_reset_bit_restart: assert property (s_soft_reset_bit_write |=> s_reset_done)
    else $error("soft reset did not reinitialise registers");

  chk_zero_bits: assert property (
    (arvalid && arready && rd_reg == acdp_pkg::ACDP_R_AUX) |=> rdata_r[4:1] == 4'h0)
    else $error("aux control zero bits read nonzero");

  chk_bod_off: assert property (
    (wr_en && wr_reg == acdp_pkg::ACDP_R_AUX && wbyte_r[6] && !wbyte_r[3]) |=> !brownout_det_en)
    else $error("brownout detection left on");

  chk_boi_noreset: assert property (boi_r [*2] |-> !brownout_reset_req)
    else $error("brownout reset in interrupt mode");

  chk_boi_event: assert property (
    (bo_rise && boi_r && !soft_rst_r) |=> stat[`ACDP_STAT_BO])
    else $error("brownout interrupt not flagged");

  chk_kbf_set: assert property ((kb_rise && !soft_rst_r) |=> kbf_r)
    else $error("keyboard wake flag not set");

  chk_cfg_route: assert property (
    xdata_req |=> cfg_access && cfg_addr == $past(ptr_value))
    else $error("data move not routed to configuration space");
endmodule

// File: testbench/acdp_core_model.sv
// Purpose: processor core model issuing pointer commands to the aux block
// Assumes: commands are one-cycle pulses launched right after a rising edge
// Notes:   load value is scrambled after its pulse so stale data is never trusted
`timescale 1ns/1ps
module acdp_core_model (
  // clock
  input  wire logic           aclk,
  // pointer commands toward the block
  output logic                ptr_inc,
  output logic                ptr_load,
  output acdp_pkg::acdp_ptr_t ptr_load_val,
  output logic                xdata_req
);
  // idle at time zero so the block never sees an unknown command
  initial begin
    ptr_inc      = 1'b0;
    ptr_load     = 1'b0;
    ptr_load_val = 16'h5a5a;
    xdata_req    = 1'b0;
  end
  // add one to whichever pointer is selected
  task automatic do_inc();
    @(posedge aclk);
    ptr_inc <= 1'b1;
    @(posedge aclk);
    ptr_inc <= 1'b0;
  endtask
  // load a 16-bit constant into the selected pointer
  task automatic do_load(input acdp_pkg::acdp_ptr_t v);
    @(posedge aclk);
    ptr_load     <= 1'b1;
    ptr_load_val <= v;
    @(posedge aclk);
    ptr_load     <= 1'b0;
    ptr_load_val <= ~v;
  endtask
  // external data move; no external bus, so it lands in configuration space
  task automatic do_xdata();
    @(posedge aclk);
    xdata_req <= 1'b1;
    @(posedge aclk);
    xdata_req <= 1'b0;
  endtask
endmodule

// File: testbench/testbench.sv
// Purpose: self-checking bench for the aux control and dual pointer block
// Assumes: one 50 MHz clock, sync active-low reset held five cycles
// Notes:   register cases run from a table; pointer, pin and reset cases by hand
`timescale 1ns/1ps
`include "acdp_defines.svh"
module testbench;
  typedef struct {
    logic [7:0] a;
    logic [7:0] w;
    logic [7:0] r;
    logic [1:0] e;
  } acdp_tb_row_t;
  logic                aclk;
  logic                aresetn;
  logic [7:0]          awaddr;
  logic                awvalid;
  logic                awready;
  logic [31:0]         wdata;
  logic [3:0]          wstrb;
  logic                wvalid;
  logic                wready;
  logic [1:0]          bresp;
  logic                bvalid;
  logic                bready;
  logic [7:0]          araddr;
  logic                arvalid;
  logic                arready;
  logic [31:0]         rdata;
  logic [1:0]          rresp;
  logic                rvalid;
  logic                rready;
  logic                ptr_inc;
  logic                ptr_load;
  acdp_pkg::acdp_ptr_t ptr_load_val;
  logic                xdata_req;
  acdp_pkg::acdp_ptr_t ptr_value;
  logic                cfg_access;
  acdp_pkg::acdp_ptr_t cfg_addr;
  logic                brownout_det;
  logic [7:0]          kb_pin_n;
  logic                brownout_det_en;
  logic                brownout_reset_req;
  logic                soft_reset_req;
  logic                irq;
  int                  n_fail;
  int                  comparisons;
  int                  n_soft_reset_bit = 0;
  logic [31:0]         rdv;
  logic [1:0]          rsp;
  // register cases: address, written byte, expected read, expected response
  acdp_tb_row_t rows [9] = '{
    '{8'h00, 8'h77, 8'h61, 2'h0}, // bits 4, 2, 1 drop, bit 3 avoided
    '{8'h00, 8'h00, 8'h00, 2'h0},
    '{8'h04, 8'ha5, 8'ha5, 2'h0},
    '{8'h08, 8'h3c, 8'h3c, 2'h0},
    '{8'h10, 8'hff, 8'h03, 2'h0},
    '{8'h14, 8'h5a, 8'h5a, 2'h0},
    '{8'h0c, 8'h03, 8'h00, 2'h0},
    '{8'h18, 8'hff, 8'h00, 2'h2},
    '{8'h02, 8'hff, 8'h00, 2'h2}
  };
  acdp_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .ptr_inc(ptr_inc), .ptr_load(ptr_load), .ptr_load_val(ptr_load_val),
    .xdata_req(xdata_req), .ptr_value(ptr_value), .cfg_access(cfg_access),
    .cfg_addr(cfg_addr), .brownout_det(brownout_det), .kb_pin_n(kb_pin_n),
    .brownout_det_en(brownout_det_en), .brownout_reset_req(brownout_reset_req),
    .soft_reset_req(soft_reset_req), .irq(irq));
  acdp_core_model u_core (.aclk(aclk), .ptr_inc(ptr_inc), .ptr_load(ptr_load),
    .ptr_load_val(ptr_load_val), .xdata_req(xdata_req));
  // 50 MHz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // count soft reset pulses as they happen
  always @(posedge aclk) begin
    if (soft_reset_req === 1'b1) n_soft_reset_bit <= n_soft_reset_bit + 1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // write: address and data offered together, each released once taken
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
    bit ah;
    bit wh;
    ah = 0;
    wh = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(ah && wh)) begin
      @(posedge aclk);
      if (!ah && awready === 1'b1) begin
        ah = 1;
        awvalid <= 1'b0;
      end
      if (!wh && wready === 1'b1) begin
        wh = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
    #1;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rdv = rdata;
    rsp = rresp;
    rready <= 1'b0;
    #1;
  endtask
  // pins change at a rising edge, then cross the synchronisers and edge detect
  task automatic pins_wait(input logic bo, input logic [7:0] kb);
    @(posedge aclk);
    brownout_det <= bo;
    kb_pin_n     <= kb;
    repeat (6) @(posedge aclk);
    #1;
  endtask
  task automatic results();
    if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // a hung handshake would stall far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    results();
  end
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    {n_fail, comparisons} = '0;
    wstrb = 4'hf;
    brownout_det = 1'b0;
    kb_pin_n = 8'hff;
    aresetn = 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk(ptr_value, 32'h0);
    chk(brownout_det_en, 32'h1);
    chk(irq, 32'h0);
    foreach (rows[i]) begin
      axi_wr(rows[i].a, rows[i].w);
      chk(rsp, rows[i].e);
      axi_rd(rows[i].a);
      chk(rdv, {24'h0, rows[i].r});
      chk(rsp, rows[i].e);
    end
    // selected pointer 0 now holds the two bytes written above
    chk(ptr_value, 32'h3ca5);
    u_core.do_inc();
    #1;
    chk(ptr_value, 32'h3ca6);
    axi_wr(`ACDP_OFS_AUX, 8'h01);
    chk(ptr_value, 32'h0);
    u_core.do_load(16'hbeef);
    #1;
    chk(ptr_value, 32'hbeef);
    u_core.do_xdata();
    #1;
    chk(cfg_access, 32'h1);
    chk(cfg_addr, 32'hbeef);
    // toggle select by incrementing the register, as software should
    axi_rd(`ACDP_OFS_AUX);
    axi_wr(`ACDP_OFS_AUX, rdv[7:0] + 8'h01);
    axi_rd(`ACDP_OFS_AUX);
    chk(rdv, 32'h0);
    chk(ptr_value, 32'h3ca6);
    axi_rd(`ACDP_OFS_PLO);
    chk(rdv, 32'ha6);
    // brownout: disabled, reset mode, interrupt mode
    axi_wr(`ACDP_OFS_AUX, 8'h40);
    chk(brownout_det_en, 32'h0);
    pins_wait(1'b1, 8'hff);
    chk(brownout_reset_req, 32'h0);
    pins_wait(1'b0, 8'hff);
    axi_wr(`ACDP_OFS_AUX, 8'h00);
    chk(brownout_det_en, 32'h1);
    pins_wait(1'b1, 8'hff);
    chk(brownout_reset_req, 32'h1);
    pins_wait(1'b0, 8'hff);
    axi_wr(`ACDP_OFS_AUX, 8'h20);
    pins_wait(1'b1, 8'hff);
    chk(brownout_reset_req, 32'h0);
    chk(irq, 32'h1);
    axi_rd(`ACDP_OFS_STAT);
    chk(rdv, 32'h1);
    axi_wr(`ACDP_OFS_STAT, 8'h01);
    chk(irq, 32'h0);
    pins_wait(1'b0, 8'hff);
    // keyboard wake on enabled pin 0, masked, cleared both ways
    axi_wr(`ACDP_OFS_KBEN, 8'h01);
    pins_wait(1'b0, 8'hfe);
    axi_rd(`ACDP_OFS_AUX);
    chk(rdv, 32'ha0);
    chk(irq, 32'h1);
    axi_wr(`ACDP_OFS_MASK, 8'h01);
    chk(irq, 32'h0);
    axi_wr(`ACDP_OFS_MASK, 8'h03);
    chk(irq, 32'h1);
    axi_wr(`ACDP_OFS_STAT, 8'h02);
    chk(irq, 32'h0);
    axi_wr(`ACDP_OFS_AUX, 8'h20);
    axi_rd(`ACDP_OFS_AUX);
    chk(rdv, 32'h20);
    pins_wait(1'b0, 8'hff);
    // soft reset clears aux, mask and the pointers, bus answer still comes
    axi_wr(`ACDP_OFS_AUX, 8'h09);
    chk(rsp, 32'h0);
    axi_rd(`ACDP_OFS_AUX);
    chk(rdv, 32'h0);
    chk(n_soft_reset_bit, 32'h1);
    chk(ptr_value, 32'h0);
    axi_rd(`ACDP_OFS_MASK);
    chk(rdv, 32'h0);
    // mid-run hardware reset after loading a pointer
    // a write without lane 0 changes nothing and still answers okay
    @(posedge aclk);
    wstrb <= 4'h0;
    axi_wr(`ACDP_OFS_PLO, 8'h55);
    chk(rsp, 32'h0);
    @(posedge aclk);
    wstrb <= 4'hf;
    axi_rd(`ACDP_OFS_PLO);
    chk(rdv, 32'h0);
    u_core.do_load(16'h1234);
    #1;
    chk(ptr_value, 32'h1234);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk(ptr_value, 32'h0);
    axi_rd(`ACDP_OFS_PHI);
    chk(rdv, 32'h0);
    results();
  end
endmodule
